/* File: logic/crc_pkg.sv */
// constants and state types for the coprocessor run control block
package crc_pkg;
    // ==================================================
    // host register offsets
    localparam logic [15:0] ADDR_PC_LO = 16'h301E;
    localparam logic [15:0] ADDR_PC_HI = 16'h301F;
    localparam logic [15:0] ADDR_STAT_LO = 16'h3030;
    localparam logic [15:0] ADDR_STAT_HI = 16'h3031;
    localparam logic [15:0] ADDR_BANK = 16'h3034;
    localparam logic [15:0] ADDR_CFG = 16'h3037;
    localparam logic [15:0] ADDR_SCR_BASE = 16'h3038;
    localparam logic [15:0] ADDR_CLK_SEL = 16'h3039;
    localparam logic [15:0] ADDR_SCR_MODE = 16'h303A;
    localparam logic [15:0] ADDR_CBR_LO = 16'h303E;
    localparam logic [15:0] ADDR_CBR_HI = 16'h303F;
    // ==================================================
    // field positions
    localparam int STAT_GO_BIT = 5;
    localparam int STAT_IRQ_BIT = 7;
    localparam int MODE_ROM_OWN_BIT = 4;
    localparam int MODE_RAM_OWN_BIT = 3;
    localparam int CFG_IRQ_MASK_BIT = 7;
    // ==================================================
    // reset values and fixed figures
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_STOP_INC = 16'h0001;
    localparam logic [11:0] CBR_RESET = 12'h000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] DUMMY_ZERO = 8'h00;
    localparam logic [7:0] DUMMY_NIB_4 = 8'h04;
    localparam logic [7:0] DUMMY_NIB_A = 8'h08;
    localparam logic [7:0] DUMMY_NIB_E = 8'h0C;
    localparam logic [7:0] DUMMY_OTHER = 8'h01;
    localparam logic [15:0] VEC_COP = 16'hFFE4;
    localparam logic [15:0] VEC_NMI = 16'hFFEA;
    // ==================================================
    // state records
    typedef struct packed {
        logic [15:0] pc;
        logic go;
        logic irq;
        logic [7:0] bank;
        logic [7:0] cfg;
        logic [7:0] scr_base;
        logic [7:0] scr_mode;
        logic clk_sel;
        logic [11:0] cbr;
        logic start;
        logic flush;
        logic rvalid;
        logic [7:0] rdata;
        logic irq_n;
        logic rom_block;
    } crc_ctl_t;
    typedef struct packed {
        logic stall;
    } crc_gate_t;
endpackage : crc_pkg

/* File: logic/crc_own_if.sv */
// ownership flags and memory requests between control and stall gate
`timescale 1ns/100ps
interface crc_own_if;
    logic go;
    logic rom_owner_flag;
    logic ram_owner_flag;
    logic rom_req;
    logic ram_req;
    logic in_cache;
    logic stall;
    modport ctl (output go, output rom_owner_flag, output ram_owner_flag,
        output rom_req, output ram_req, output in_cache, input stall);
    modport gate (input go, input rom_owner_flag, input ram_owner_flag,
        input rom_req, input ram_req, input in_cache, output stall);
endinterface : crc_own_if

/* File: logic/crc_stall_gate.sv */
// wait stall for cartridge accesses the coprocessor does not own
`timescale 1ns/100ps
module crc_stall_gate (
    input wire logic sys_clk,
    input wire logic rst,
    crc_own_if.gate own
);
    crc_pkg::crc_gate_t st_ff;
    crc_pkg::crc_gate_t nxt_st;

    // ==================================================
    // stall logic
    // cache fetches never stall, so the core keeps running while the host holds both buses
    always_comb begin
        nxt_st = st_ff;
        nxt_st.stall = own.go && !own.in_cache &&
            ((own.rom_req && !own.rom_owner_flag) ||
             (own.ram_req && !own.ram_owner_flag));
        if (rst) begin
            nxt_st.stall = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_ff <= nxt_st;
    end

    assign own.stall = st_ff.stall;

    // ==================================================
    // checks
    chk_rom_wait_entry: assert property (@(posedge sys_clk) disable iff (rst)
        (own.go && !own.in_cache && own.rom_req && !own.rom_owner_flag) |=> own.stall)
        else $error("rom access without ownership did not stall");
    chk_wait_release: assert property (@(posedge sys_clk) disable iff (rst)
        (own.stall && own.rom_owner_flag && own.ram_owner_flag) |=> !own.stall)
        else $error("stall held after ownership returned");
    chk_ram_wait_entry: assert property (@(posedge sys_clk) disable iff (rst)
        (own.go && !own.in_cache && own.ram_req && !own.ram_owner_flag) |=> own.stall)
        else $error("ram access without ownership did not stall");
endmodule : crc_stall_gate

/* File: logic/crc_dummy_rom.sv */
// substitute byte for host rom reads while the coprocessor owns rom
`timescale 1ns/100ps
module crc_dummy_rom (
    input wire logic [3:0] nibble,
    output logic [7:0] dummy
);
    // ==================================================
    // the byte pairs form the substitute vectors 0100, 0104, 0108, 010c
    always_comb begin
        unique case (nibble)
            4'h0, 4'h2, 4'h6, 4'h8, 4'hC: dummy = crc_pkg::DUMMY_ZERO;
            4'h4: dummy = crc_pkg::DUMMY_NIB_4;
            4'hA: dummy = crc_pkg::DUMMY_NIB_A;
            4'hE: dummy = crc_pkg::DUMMY_NIB_E;
            default: dummy = crc_pkg::DUMMY_OTHER;
        endcase
    end
endmodule : crc_dummy_rom

/* File: logic/crc_run_control.sv */
// run control, host register port and ownership of the coprocessor
// Summary of operation
// - after reset the coprocessor idles and fetches nothing until started.
// - host write of the program counter upper byte starts execution at that address.
// - stop instruction clears run flag, raises host interrupt, enters idle.
// - after stop the program counter holds the preceding instruction value plus one.
// - host writing zero to run flag stops, flushes cache, zeroes cache base.
// - rom owner cleared while running stalls at the next rom access.
// - setting the owner flag again releases the stall and processing resumes.
// - ram owner flag gives the same stall and resume for cartridge ram.
// - while running with rom owner set, host rom accesses never reach rom.
// - host vector reads then return substitute vectors in host work ram.
// - any host rom read then returns a byte chosen by the low nibble.
// - completion sets the interrupt flag at status bit 15.
// - host read of the status interrupt flag clears it.
// - config bit 7 set suppresses the interrupt output to the host.
// - status run flag reads one while executing and zero when idle.
// - each owner flag gives its bus to host at zero, coprocessor at one.
`timescale 1ns/100ps
module crc_run_control (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic host_rom_sel,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    output logic host_rom_block,
    output logic host_irq_n,
    input wire logic core_stop,
    input wire logic [15:0] core_stop_base,
    input wire logic core_cbr_load,
    input wire logic [11:0] core_cbr_value,
    input wire logic core_rom_req,
    input wire logic core_ram_req,
    input wire logic core_in_cache,
    output logic core_run,
    output logic core_start,
    output logic core_wait,
    output logic cache_flush,
    output logic [15:0] prog_counter,
    output logic [11:0] cache_base,
    output logic [7:0] code_bank_reg,
    output logic [7:0] config_reg,
    output logic [7:0] screen_base_reg,
    output logic [7:0] screen_mode_reg,
    output logic clock_select_reg
);
    crc_pkg::crc_ctl_t st_ff;
    crc_pkg::crc_ctl_t nxt_st;
    crc_own_if own ();
    logic reg_wr;
    logic reg_rd;
    logic rom_rd;
    logic [7:0] dummy_byte;

    // ==================================================
    // submodules
    crc_stall_gate u_gate (
        .sys_clk(sys_clk),
        .rst(rst),
        .own(own)
    );

    crc_dummy_rom u_dummy (
        .nibble(host_addr[3:0]),
        .dummy(dummy_byte)
    );

    assign own.go = st_ff.go;
    assign own.rom_owner_flag = st_ff.scr_mode[crc_pkg::MODE_ROM_OWN_BIT];
    assign own.ram_owner_flag = st_ff.scr_mode[crc_pkg::MODE_RAM_OWN_BIT];
    assign own.rom_req = core_rom_req;
    assign own.ram_req = core_ram_req;
    assign own.in_cache = core_in_cache;

    // ==================================================
    // host access decode
    assign reg_wr = host_wr && !host_rom_sel;
    assign reg_rd = host_rd && !host_rom_sel;
    assign rom_rd = host_rd && host_rom_sel;

    // ==================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.start = 1'b0;
        nxt_st.flush = 1'b0;
        nxt_st.rvalid = 1'b0;
        if (core_cbr_load) begin
            nxt_st.cbr = core_cbr_value;
        end
        // status read clears the flag first so that a stop in the same
        // cycle sets it again and the event is not lost
        if (reg_rd && host_addr == crc_pkg::ADDR_STAT_HI) begin
            nxt_st.irq = 1'b0;
        end
        if (core_stop && st_ff.go) begin
            nxt_st.go = 1'b0;
            nxt_st.irq = 1'b1;
            nxt_st.pc = core_stop_base + crc_pkg::PC_STOP_INC;
        end
        if (reg_wr) begin
            unique case (host_addr)
                crc_pkg::ADDR_PC_LO: nxt_st.pc[7:0] = host_wdata;
                crc_pkg::ADDR_PC_HI: begin
                    nxt_st.pc[15:8] = host_wdata;
                    nxt_st.go = 1'b1;
                    nxt_st.start = 1'b1;
                end
                crc_pkg::ADDR_STAT_LO: begin
                    if (!host_wdata[crc_pkg::STAT_GO_BIT]) begin
                        nxt_st.go = 1'b0;
                        nxt_st.flush = 1'b1;
                        nxt_st.cbr = crc_pkg::CBR_RESET;
                    end
                end
                crc_pkg::ADDR_BANK: nxt_st.bank = host_wdata;
                crc_pkg::ADDR_CFG: nxt_st.cfg = host_wdata;
                crc_pkg::ADDR_SCR_BASE: nxt_st.scr_base = host_wdata;
                crc_pkg::ADDR_CLK_SEL: nxt_st.clk_sel = host_wdata[0];
                crc_pkg::ADDR_SCR_MODE: nxt_st.scr_mode = host_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            nxt_st.rvalid = 1'b1;
            unique case (host_addr)
                crc_pkg::ADDR_PC_LO: nxt_st.rdata = st_ff.pc[7:0];
                crc_pkg::ADDR_PC_HI: nxt_st.rdata = st_ff.pc[15:8];
                crc_pkg::ADDR_STAT_LO: nxt_st.rdata = {2'b00, st_ff.go, 5'b00000};
                crc_pkg::ADDR_STAT_HI: nxt_st.rdata = {st_ff.irq, 7'b0000000};
                crc_pkg::ADDR_BANK: nxt_st.rdata = st_ff.bank;
                crc_pkg::ADDR_CBR_LO: nxt_st.rdata = {st_ff.cbr[3:0], 4'h0};
                crc_pkg::ADDR_CBR_HI: nxt_st.rdata = st_ff.cbr[11:4];
                default: nxt_st.rdata = crc_pkg::BYTE_RESET;
            endcase
        end else if (rom_rd && st_ff.rom_block) begin
            // the rom is cut off; the host still gets vectors into work ram
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = dummy_byte;
        end
        if (rst) begin
            nxt_st.pc = crc_pkg::PC_RESET;
            nxt_st.go = 1'b0;
            nxt_st.irq = 1'b0;
            nxt_st.bank = crc_pkg::BYTE_RESET;
            nxt_st.cfg = crc_pkg::BYTE_RESET;
            nxt_st.scr_base = crc_pkg::BYTE_RESET;
            nxt_st.scr_mode = crc_pkg::BYTE_RESET;
            nxt_st.clk_sel = 1'b0;
            nxt_st.cbr = crc_pkg::CBR_RESET;
            nxt_st.start = 1'b0;
            nxt_st.flush = 1'b0;
            nxt_st.rvalid = 1'b0;
            nxt_st.rdata = crc_pkg::BYTE_RESET;
        end
        // derived outputs follow the new state so they line up with it
        nxt_st.irq_n = !(nxt_st.irq && !nxt_st.cfg[crc_pkg::CFG_IRQ_MASK_BIT]);
        nxt_st.rom_block = nxt_st.go && nxt_st.scr_mode[crc_pkg::MODE_ROM_OWN_BIT];
    end

    always_ff @(posedge sys_clk) begin
        st_ff <= nxt_st;
    end

    // ==================================================
    // outputs
    assign host_rdata = st_ff.rdata;
    assign host_rvalid = st_ff.rvalid;
    assign host_rom_block = st_ff.rom_block;
    assign host_irq_n = st_ff.irq_n;
    assign core_run = st_ff.go;
    assign core_start = st_ff.start;
    assign core_wait = own.stall;
    assign cache_flush = st_ff.flush;
    assign prog_counter = st_ff.pc;
    assign cache_base = st_ff.cbr;
    assign code_bank_reg = st_ff.bank;
    assign config_reg = st_ff.cfg;
    assign screen_base_reg = st_ff.scr_base;
    assign screen_mode_reg = st_ff.scr_mode;
    assign clock_select_reg = st_ff.clk_sel;

    // ==================================================
    // checks
    chk_idle_after_reset: assert property (@(posedge sys_clk)
        rst |=> !core_run && !core_start && host_irq_n)
        else $error("not idle after reset");
    chk_start_on_pc: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && host_addr == crc_pkg::ADDR_PC_HI) |=>
        core_run && core_start && prog_counter[15:8] == $past(host_wdata))
        else $error("upper counter write did not start");
    chk_low_no_start: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && host_addr == crc_pkg::ADDR_PC_LO) |=> !core_start)
        else $error("lower counter write started execution");
    chk_stop_idle: assert property (@(posedge sys_clk) disable iff (rst)
        (core_stop && core_run && !reg_wr) |=>
        !core_run && (!host_irq_n || config_reg[crc_pkg::CFG_IRQ_MASK_BIT]))
        else $error("stop did not idle and interrupt");
    chk_stop_counter: assert property (@(posedge sys_clk) disable iff (rst)
        (core_stop && core_run && !reg_wr) |=> prog_counter == $past(core_stop_base) + 16'h0001)
        else $error("counter after stop wrong");
    chk_forced_stop: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && host_addr == crc_pkg::ADDR_STAT_LO && !host_wdata[crc_pkg::STAT_GO_BIT]) |=>
        !core_run && cache_flush && cache_base == crc_pkg::CBR_RESET)
        else $error("forced stop incomplete");
    chk_vector_sub: assert property (@(posedge sys_clk) disable iff (rst)
        (rom_rd && host_rom_block && host_addr == crc_pkg::VEC_COP) |=>
        host_rvalid && host_rdata == 8'h04)
        else $error("substitute vector low byte wrong");
    chk_dummy_nmi: assert property (@(posedge sys_clk) disable iff (rst)
        (rom_rd && host_rom_block && host_addr == crc_pkg::VEC_NMI) |=> host_rdata == 8'h08)
        else $error("dummy byte for nibble a wrong");
    chk_rom_blocked: assert property (@(posedge sys_clk) disable iff (rst)
        host_rom_block |-> core_run && screen_mode_reg[4])
        else $error("rom block without run and owner");
    chk_irq_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && host_addr == crc_pkg::ADDR_STAT_HI && !core_stop) |=> host_irq_n)
        else $error("status read did not clear interrupt");
    chk_irq_mask: assert property (@(posedge sys_clk) disable iff (rst)
        config_reg[7] |-> host_irq_n)
        else $error("masked interrupt reached host");
    chk_run_flag: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && host_addr == crc_pkg::ADDR_STAT_LO) |=>
        host_rdata[crc_pkg::STAT_GO_BIT] == $past(core_run))
        else $error("run flag read wrong");
endmodule : crc_run_control

/* File: testbench/crc_host_model.sv */
// host cpu model driving the register port and cartridge rom reads
`timescale 1ns/100ps
module crc_host_model (
    input wire logic sys_clk,
    output logic [15:0] host_addr,
    output logic [7:0] host_wdata,
    output logic host_wr,
    output logic host_rd,
    output logic host_rom_sel,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid
);
    // ==================================================
    // bus handling
    initial begin
        host_addr = 16'h0000;
        host_wdata = 8'h00;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_rom_sel = 1'b0;
    end
    // a released bus drops its strobes and shows the inverse of its last address and data, so stale data never passes
    task automatic release_bus();
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = ~host_addr;
        host_wdata = ~host_wdata;
    endtask : release_bus
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        host_addr = a;
        host_wdata = d;
        host_rom_sel = 1'b0;
        host_wr = 1'b1;
        @(negedge sys_clk);
        release_bus();
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic rom, output logic [7:0] d);
        int n;
        @(negedge sys_clk);
        host_addr = a;
        host_rom_sel = rom;
        host_rd = 1'b1;
        @(negedge sys_clk);
        release_bus();
        n = 0;
        while (host_rvalid !== 1'b1 && n < 3) begin
            @(negedge sys_clk);
            n++;
        end
        d = (host_rvalid === 1'b1) ? host_rdata : 8'hXX;
    endtask : rd
endmodule : crc_host_model

/* File: testbench/testbench.sv */
// self-checking bench for the coprocessor run control block
`timescale 1ns/100ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] host_addr;
    logic [7:0] host_wdata;
    logic host_wr;
    logic host_rd;
    logic host_rom_sel;
    logic [7:0] host_rdata;
    logic host_rvalid;
    logic host_rom_block;
    logic host_irq_n;
    logic core_stop = 1'b0;
    logic [15:0] core_stop_base = 16'h0000;
    logic core_cbr_load = 1'b0;
    logic [11:0] core_cbr_value = 12'h000;
    logic core_rom_req = 1'b0;
    logic core_ram_req = 1'b0;
    logic core_in_cache = 1'b0;
    logic core_run, core_start, core_wait, cache_flush, clock_select_reg;
    logic [15:0] prog_counter;
    logic [11:0] cache_base;
    logic [7:0] code_bank_reg, config_reg, screen_base_reg, screen_mode_reg;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] pc, base, a;
    logic [11:0] cbr;
    logic [15:0] vec_addr [5] = '{16'hFFE4, 16'hFFE6, 16'hFFE8, 16'hFFEA, 16'hFFEE};
    logic [15:0] vec_exp [5] = '{16'h0104, 16'h0100, 16'h0100, 16'h0108, 16'h010C};

    always #20 sys_clk = ~sys_clk;

    crc_host_model host (.sys_clk(sys_clk), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_wr(host_wr), .host_rd(host_rd), .host_rom_sel(host_rom_sel),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid));

    crc_run_control DUT (.sys_clk(sys_clk), .rst(rst), .host_addr(host_addr),
        .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
        .host_rom_sel(host_rom_sel), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
        .host_rom_block(host_rom_block), .host_irq_n(host_irq_n), .core_stop(core_stop),
        .core_stop_base(core_stop_base), .core_cbr_load(core_cbr_load),
        .core_cbr_value(core_cbr_value), .core_rom_req(core_rom_req),
        .core_ram_req(core_ram_req), .core_in_cache(core_in_cache), .core_run(core_run),
        .core_start(core_start), .core_wait(core_wait), .cache_flush(cache_flush),
        .prog_counter(prog_counter), .cache_base(cache_base), .code_bank_reg(code_bank_reg),
        .config_reg(config_reg), .screen_base_reg(screen_base_reg),
        .screen_mode_reg(screen_mode_reg), .clock_select_reg(clock_select_reg));

    // ==================================================
    // helpers
    task automatic finish_test();
        $display("TB: checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : check
    task automatic rd_chk(input logic [15:0] ad, input logic rom, input logic [7:0] e,
        input string nm);
        logic [7:0] d;
        host.rd(ad, rom, d);
        check(nm, {8'h00, e}, {8'h00, d});
    endtask : rd_chk
    task automatic start(input logic [7:0] mode, input logic [7:0] cfg, input logic [15:0] p);
        host.wr(16'h3034, 8'h01);
        host.wr(16'h3038, 8'h02);
        host.wr(16'h303A, mode);
        host.wr(16'h3037, cfg);
        host.wr(16'h3039, 8'h01);
        host.wr(16'h301E, p[7:0]);
        host.wr(16'h301F, p[15:8]);
    endtask : start
    task automatic stop_core(input logic [15:0] b);
        @(negedge sys_clk);
        core_stop = 1'b1;
        core_stop_base = b;
        @(negedge sys_clk);
        core_stop = 1'b0;
        core_stop_base = ~b;
    endtask : stop_core
    function automatic logic [7:0] dummy_byte(input logic [3:0] n);
        case (n)
            4'h0, 4'h2, 4'h6, 4'h8, 4'hC: return 8'h00;
            4'h4: return 8'h04;
            4'hA: return 8'h08;
            4'hE: return 8'h0C;
            default: return 8'h01;
        endcase
    endfunction : dummy_byte

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            $display("[FAIL] timeout expected done seen hang");
            n_mismatch++;
            finish_test();
        end
    end

    // ==================================================
    // tests
    initial begin
        void'($urandom(94687));
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        check("run", 16'h0000, {15'h0, core_run});
        check("irq_n", 16'h0001, {15'h0, host_irq_n});
        check("pc", 16'h0000, prog_counter);
        rd_chk(16'h3050, 1'b0, 8'h00, "unmapped");
        $display("TB: test reset done");
        for (int i = 0; i < 4; i++) begin
            pc = 16'($urandom);
            base = (i == 0) ? 16'hFFFF : 16'($urandom);
            start(8'h18, 8'h00, pc);
            check("start", 16'h0001, {15'h0, core_start});
            check("pc", pc, prog_counter);
            check("run", 16'h0001, {15'h0, core_run});
            rd_chk(16'h3030, 1'b0, 8'h20, "go");
            stop_core(base);
            check("pc_stop", base + 16'h0001, prog_counter);
            check("run", 16'h0000, {15'h0, core_run});
            check("irq_n", 16'h0000, {15'h0, host_irq_n});
            rd_chk(16'h3031, 1'b0, 8'h80, "irq_flag");
            check("irq_n", 16'h0001, {15'h0, host_irq_n});
            rd_chk(16'h3031, 1'b0, 8'h00, "irq_clear");
        end
        stop_core(16'h1234);
        check("idle_stop", base + 16'h0001, prog_counter);
        start(8'h00, 8'h80, 16'h0200);
        check("cfg", 16'h0080, {8'h00, config_reg});
        stop_core(16'h0300);
        check("irq_mask", 16'h0001, {15'h0, host_irq_n});
        rd_chk(16'h3031, 1'b0, 8'h80, "masked_flag");
        $display("TB: test start_stop done");
        cbr = 12'h800 | 12'($urandom);
        @(negedge sys_clk);
        core_cbr_load = 1'b1;
        core_cbr_value = cbr;
        @(negedge sys_clk);
        core_cbr_load = 1'b0;
        rd_chk(16'h303E, 1'b0, {cbr[3:0], 4'h0}, "cbr_lo");
        rd_chk(16'h303F, 1'b0, cbr[11:4], "cbr_hi");
        host.wr(16'h303E, 8'h00);
        check("cbr_ro", {4'h0, cbr}, {4'h0, cache_base});
        start(8'h18, 8'h00, 16'h0400);
        host.wr(16'h3030, 8'h20);
        check("go_one", 16'h0001, {15'h0, core_run});
        host.wr(16'h3030, 8'h00);
        check("forced", 16'h0000, {15'h0, core_run});
        check("flush", 16'h0001, {15'h0, cache_flush});
        check("cbr_zero", 16'h0000, {4'h0, cache_base});
        $display("TB: test forced_stop done");
        start(8'h18, 8'h00, 16'h0500);
        check("bank", 16'h0001, {8'h00, code_bank_reg});
        check("scr_base", 16'h0002, {8'h00, screen_base_reg});
        check("scr_mode", 16'h0018, {8'h00, screen_mode_reg});
        check("cfg", 16'h0000, {8'h00, config_reg});
        check("clk_sel", 16'h0001, {15'h0, clock_select_reg});
        core_rom_req = 1'b1;
        core_ram_req = 1'b1;
        repeat (2) @(negedge sys_clk);
        check("owned", 16'h0000, {15'h0, core_wait});
        check("rom_block", 16'h0001, {15'h0, host_rom_block});
        for (int n = 0; n < 16; n++) begin
            a = 16'($urandom);
            a[3:0] = n[3:0];
            rd_chk(a, 1'b1, dummy_byte(n[3:0]), "dummy");
        end
        foreach (vec_addr[k]) begin
            rd_chk(vec_addr[k], 1'b1, vec_exp[k][7:0], "vec_lo");
            rd_chk(vec_addr[k] + 16'h0001, 1'b1, vec_exp[k][15:8], "vec_hi");
        end
        host.wr(16'h303A, 8'h08);
        repeat (2) @(negedge sys_clk);
        check("rom_wait", 16'h0001, {15'h0, core_wait});
        check("rom_free", 16'h0000, {15'h0, host_rom_block});
        core_in_cache = 1'b1;
        repeat (2) @(negedge sys_clk);
        check("cache_run", 16'h0000, {15'h0, core_wait});
        core_in_cache = 1'b0;
        host.wr(16'h303A, 8'h18);
        repeat (2) @(negedge sys_clk);
        check("rom_resume", 16'h0000, {15'h0, core_wait});
        host.wr(16'h303A, 8'h10);
        repeat (2) @(negedge sys_clk);
        check("ram_wait", 16'h0001, {15'h0, core_wait});
        host.wr(16'h303A, 8'h18);
        repeat (2) @(negedge sys_clk);
        check("ram_resume", 16'h0000, {15'h0, core_wait});
        check("still_run", 16'h0001, {15'h0, core_run});
        core_rom_req = 1'b0;
        core_ram_req = 1'b0;
        host.wr(16'h3030, 8'h00);
        check("unblock", 16'h0000, {15'h0, host_rom_block});
        $display("TB: test ownership done");
        finish_test();
    end
endmodule : testbench
